// file: verilog/bpm_regs_defs.vh
// Constants for the bridge power management register bank.
// Included by the register bank module; holds definitions only.
`ifndef BPM_REGS_DEFS_VH
`define BPM_REGS_DEFS_VH

`define BPM_OFS_PMCSR 8'h4c
`define BPM_OFS_EXT 8'h4e
`define BPM_OFS_DATA 8'h4f
`define BPM_PMCSR_RESET 16'h0008
`define BPM_EXT_RESET 8'h40
`define BPM_DATA_RESET 8'h00
`define BPM_STATE_D0 2'h0
`define BPM_STATE_D3HOT 2'h3
`define BPM_BIT_WAKE_EN 8
`define BPM_BIT_NO_SOFT_RST 3
`define BPM_BIT_CLK_STOP 7
`define BPM_BIT_B2 6
`define BPM_CFG_DWORD 6'h13
`define BPM_PMCSR_RW_MASK 16'h0103
`define BPM_STATE_MSB 1
`define BPM_STATE_LSB 0
`define BPM_ZERO_WORD 32'h0000_0000

`endif

// file: verilog/bpm_regs.v
// Power management control/status registers of the bridge function.
// Assumes configuration accesses arrive as one-cycle dword requests with byte enables.
//
// Contract
// RULE1: Power state field bits 1:0 read/write, reset D0, encodes D0..D3hot.
// RULE2: Leaving D3hot for D0 causes no internal reset; contents are kept.
// RULE3: No-soft-reset bit 3 mirrors the pm revision select control bit.
// RULE4: Wake event status bit 15 always reads 0.
// RULE5: Data scale field bits 14:13 always reads 00.
// RULE6: Data select field bits 12:9 always reads zero.
// RULE7: Wake enable bit 8 is plain storage, reset 0.
// RULE8: Reserved bits 7:4 and 2 read zero.
// RULE9: Extension bit 7 mirrors the secondary clock stop enable.
// RULE10: Extension bit 6 always reads 1, bus B2 in D3.
// RULE11: Extension bits 5:0 read zero.
// RULE12: Power data register always reads zero.
// RULE13: Writes to read-only or reserved fields are ignored.
`timescale 1ns/1ps
`include "bpm_regs_defs.vh"

module bpm_regs (
  input wire mclk_i,
  input wire rst_i,
  input wire cfg_req_i,
  input wire cfg_we_i,
  input wire [5:0] cfg_dword_i,
  input wire [3:0] cfg_be_i,
  input wire [31:0] cfg_wdata_i,
  input wire pm_revision_select_i,
  input wire secondary_clock_stop_enable_i,
  output reg [31:0] cfg_rdata_o,
  output reg cfg_ack_o,
  output reg [1:0] device_power_state_o,
  output reg wake_event_enable_o
);

  // Widths of the pieces of the configuration dword.
  localparam PMCSR_W = 16;
  localparam BYTE_W = 8;
  localparam LANES_W = 2;

  // Kinds of request seen on one edge.
  localparam KIND_IDLE = 2'h0;
  localparam KIND_READ = 2'h1;
  localparam KIND_WRITE = 2'h2;
  localparam KIND_MISS = 2'h3;

  // Stored fields.
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg wake_en_reg;
  reg wake_en_next;

  // Mirrors of the general control settings.
  reg rev_sel_reg;
  reg clk_stop_reg;
  wire rev_sel_next;
  wire clk_stop_next;

  // Bus response.
  reg ack_next;
  reg [31:0] rdata_next;

  // Request decode and write merge.
  wire hit;
  wire [1:0] req_kind;
  wire [LANES_W-1:0] lane_en;
  wire [PMCSR_W-1:0] rw_mask;
  wire [PMCSR_W-1:0] cur_pmcsr;
  wire [PMCSR_W-1:0] merged;

  // Fields of the control/status half-word.
  wire wake_stat_f;
  wire [1:0] data_scale_f;
  wire [3:0] data_sel_f;
  wire [3:0] rsvd_mid_f;
  wire no_soft_rst_f;
  wire rsvd_low_f;

  // Fields of the extension byte and the data byte.
  wire clk_stop_f;
  wire b2_f;
  wire [5:0] rsvd_ext_f;
  wire [7:0] pdata;

  // Assembled read word.
  wire [15:0] pmcsr;
  wire [7:0] ext;
  wire [31:0] rd_word;

  assign hit = (cfg_dword_i == `BPM_CFG_DWORD);
  assign req_kind = !cfg_req_i ? KIND_IDLE :
                    !hit ? KIND_MISS :
                    cfg_we_i ? KIND_WRITE : KIND_READ;

  // RULE3 RULE9 mirrors follow the control inputs one edge late.
  assign rev_sel_next = pm_revision_select_i;
  assign clk_stop_next = secondary_clock_stop_enable_i;

  // RULE4 wake status never set.
  assign wake_stat_f = 1'b0;
  // RULE5 data scale unused.
  assign data_scale_f = 2'h0;
  // RULE6 data select unused.
  assign data_sel_f = 4'h0;
  // RULE8 reserved bits zero.
  assign rsvd_mid_f = 4'h0;
  assign rsvd_low_f = 1'b0;
  // RULE3 no soft reset indication.
  assign no_soft_rst_f = rev_sel_reg;
  assign pmcsr = {wake_stat_f, data_scale_f, data_sel_f, wake_en_reg, rsvd_mid_f,
                  no_soft_rst_f, rsvd_low_f, state_reg};

  // RULE9 clock stop mirror.
  assign clk_stop_f = clk_stop_reg;
  // RULE10 bus state B2.
  assign b2_f = 1'b1;
  // RULE11 reserved bits zero.
  assign rsvd_ext_f = 6'h00;
  assign ext = {clk_stop_f, b2_f, rsvd_ext_f};

  // RULE12 power data zero.
  assign pdata = `BPM_DATA_RESET;
  assign rd_word = {pdata, ext, pmcsr};

  // RULE13 writable bit mask.
  assign rw_mask = `BPM_PMCSR_RW_MASK;
  assign lane_en = cfg_be_i[LANES_W-1:0];
  assign cur_pmcsr = {7'h00, wake_en_reg, 6'h00, state_reg};

  // A bit takes write data only when its byte lane is enabled and it is writable,
  // so fixed and reserved bits can never be disturbed by a write.
  genvar gi;
  generate
    for (gi = 0; gi < PMCSR_W; gi = gi + 1) begin : g_merge
      assign merged[gi] = (lane_en[gi / BYTE_W] && rw_mask[gi]) ?
                          cfg_wdata_i[gi] : cur_pmcsr[gi];
    end
  endgenerate

  // Next values for the stored fields and the bus response.
  always @* begin
    ack_next = 1'b0;
    rdata_next = `BPM_ZERO_WORD;
    state_next = state_reg;
    wake_en_next = wake_en_reg;
    case (req_kind)
      KIND_IDLE: begin
        ack_next = 1'b0;
      end
      KIND_READ: begin
        ack_next = 1'b1;
        rdata_next = rd_word;
      end
      // RULE1 RULE2 RULE7 plain store.
      KIND_WRITE: begin
        ack_next = 1'b1;
        state_next = merged[`BPM_STATE_MSB:`BPM_STATE_LSB];
        wake_en_next = merged[`BPM_BIT_WAKE_EN];
      end
      // A miss is acknowledged with zero data and changes nothing.
      KIND_MISS: begin
        ack_next = 1'b1;
      end
      default: begin
        ack_next = 1'b0;
      end
    endcase
  end

  // RULE3 RULE9 mirror registers.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rev_sel_reg <= 1'b0;
      clk_stop_reg <= 1'b0;
    end else begin
      rev_sel_reg <= rev_sel_next;
      clk_stop_reg <= clk_stop_next;
    end
  end

  // RULE2 leaving D3hot is an ordinary store; nothing else is cleared.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= `BPM_STATE_D0;
      wake_en_reg <= 1'b0;
      device_power_state_o <= `BPM_STATE_D0;
      wake_event_enable_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      wake_en_reg <= wake_en_next;
      device_power_state_o <= state_next;
      wake_event_enable_o <= wake_en_next;
    end
  end

  // Bus response registers.
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= `BPM_ZERO_WORD;
    end else begin
      cfg_ack_o <= ack_next;
      cfg_rdata_o <= rdata_next;
    end
  end

endmodule // bpm_regs

// file: tb/bpm_chk.sv
`timescale 1ns/1ps
module bpm_chk(input wire mclk_i,rst_i,cfg_req_i,cfg_we_i,pm_revision_select_i,
secondary_clock_stop_enable_i,cfg_ack_o,wake_event_enable_o,input wire [5:0] cfg_dword_i,
input wire [3:0] cfg_be_i,input wire [31:0] cfg_wdata_i,cfg_rdata_o,
input wire [1:0] device_power_state_o);
default clocking @(posedge mclk_i); endclocking
default disable iff (rst_i);
wire rv=pm_revision_select_i;
wire ce=secondary_clock_stop_enable_i;
wire rd=cfg_req_i&&cfg_dword_i==6'h13&&!cfg_we_i;
wire wr=cfg_req_i&&cfg_dword_i==6'h13&&cfg_we_i;
AST_PS: assert property(wr&&cfg_be_i[0]|=>
device_power_state_o==$past(cfg_wdata_i[1:0])) else $error("state");
AST_WE: assert property(wr&&cfg_be_i[1]|=>
wake_event_enable_o==$past(cfg_wdata_i[8])) else $error("wake");
AST_KEEP: assert property(!wr|=>$stable(device_power_state_o)) else $error("kept");
AST_NSR: assert property(rd&&$stable(rv)&&!$past(rst_i)|=>
cfg_rdata_o[3]==$past(rv)) else $error("nsr");
AST_CS: assert property(rd&&$stable(ce)&&!$past(rst_i)|=>
cfg_rdata_o[23]==$past(ce)) else $error("clk");
AST_B2: assert property(rd|=>cfg_rdata_o[22]) else $error("b2");
AST_Z1: assert property(cfg_ack_o|->cfg_rdata_o[15:9]==0) else $error("z1");
AST_Z2: assert property(cfg_ack_o|->(cfg_rdata_o&32'hff3f_00f4)==0) else $error("z2");
cover property(rd);
cover property(wr&&cfg_be_i[0]);
cover property(wr&&cfg_be_i[1]);
endmodule // bpm_chk

// file: tb/bpm_regs_tb.sv
`timescale 1ns/1ps
module bpm_regs_tb;
reg c=0,r=1,q=0,w=0,rv=0,ce=0;reg [5:0] d=0;reg [3:0] b=0;reg [31:0] wd=0,e;
wire [31:0] rdo;wire a,wk;wire [1:0] st;
integer n_mismatch=0,comparisons=0,cyc=0,i,ps=0,k=0;
bpm_regs uut(.mclk_i(c),.rst_i(r),.cfg_req_i(q),.cfg_we_i(w),.cfg_dword_i(d),.cfg_be_i(b),
.cfg_wdata_i(wd),.pm_revision_select_i(rv),.secondary_clock_stop_enable_i(ce),
.cfg_rdata_o(rdo),.cfg_ack_o(a),.device_power_state_o(st),.wake_event_enable_o(wk));
initial forever #10 c=~c;
always @(posedge c) if(++cyc==3000) begin n_mismatch++;stop_test;end
task stop_test;begin $display("mismatches %0d comparisons %0d",n_mismatch,comparisons);
if(n_mismatch==0&&comparisons>0) $display("ALL CHECKS OK"); else $display("CHECKS NOT OK");
$finish;end endtask
initial begin
i=$urandom(36);repeat(10)@(posedge c);r<=0;
for(i=0;i<200;i++) begin
@(posedge c);rv<=1'($urandom);ce<=1'($urandom);
@(posedge c);q<=1;w<=1'($urandom);d<={5'h09,1'($urandom)};b<=4'($urandom);wd<=$urandom;
@(posedge c);q<=0;#1;comparisons++;
e=(!w&&d[0])?{8'h0,ce,7'h40,7'h0,k[0],4'h0,rv,1'b0,ps[1:0]}:32'h0;
if(w&&d[0]&&b[0]) ps=wd[1:0];
if(w&&d[0]&&b[1]) k=wd[8];
if({a,rdo,st,wk}!=={1'b1,e,ps[1:0],k[0]}) begin
n_mismatch++;$display("[FAIL] %0t readback or state differs",$time);end
end
stop_test;
end
endmodule // bpm_regs_tb
bind bpm_regs bpm_chk chk(.*);
